/* File: logic/hsp_host_port.sv */
`default_nettype none
// Operation
// RL1 - in monitor mode, low 16 bits of newest ring entry readable at 0x10
// RL2 - ring entry bits 19..16 in bits 3..0 at 0x12, upper bits zero
// RL3 - host joins pointer and map, adds its own top four bits
// RL4 - last terminal status and last received command words readable
// RL5 - run status read at 0x18, written only through 0x98
// RL6 - run status cleared by reset, clear command, control bit 5
// RL7 - bit 15 high while running, self-testing or servicing clear
// RL8 - bits 14 and 13 set on level-A and level-B mask matches
// RL9 - bit 11 on command done, bit 12 when level-B reports it
// RL10 - bits 10, 9, 8 flag arithmetic, host, loopback test failures
// RL11 - bit 7 set once host requested orderly shutdown
// RL12 - bits 6..4 give current mode: 0, 1, 2 or 4
// RL13 - bit 3 late level-B, bit 2 test done, bit 1 test failed
// RL14 - bit 0 error, maskable except during power-up
// RL15 - level-A and level-B vectors held, given on interrupt acknowledge
// RL16 - window 0x80..0xff serviced by firmware
// RL17 - window write latched, firmware asked only after cycle ends
// RL18 - bit 11 held until read again after having been seen
// RL19 - host polls bit 11, clears it, then issues next command
// RL20 - window read gives stale data, then firmware fetches value
// RL21 - host repeats the read after bit 11 handshake for valid data
// RL22 - start mode in bits 2..0, upper bits zero
// RL23 - both terminal/monitor starts show mode 4
// RL24 - status read clears only bit 11, only if already seen set
module hsp_host_port (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // host register port
  input wire hsp_pkg::hsp_host_req_t host_i,
  output logic host_ack_o,
  output logic [15:0] host_rdata_o,
  // interrupt acknowledge
  input wire logic iack_req_i,
  input wire logic iack_lvl_b_i,
  output logic iack_ack_o,
  output logic [15:0] iack_vec_o,
  // protocol engine side
  input wire hsp_pkg::hsp_engine_t eng_i,
  input wire hsp_pkg::hsp_fw_t fw_i,
  output hsp_pkg::hsp_svc_t svc_o,
  output logic [15:0] run_status_o
);

  // ===================================================
  // elaboration checks
  if (hsp_pkg::DW != 16) begin : g_dw_chk
    $error("host port is 16 bits wide");
  end
  if (hsp_pkg::MW != 20) begin : g_mw_chk
    $error("ring address is 20 bits");
  end

  // ===================================================
  // state
  typedef struct packed {
    logic [15:0] sts;
    logic [15:0] vec_a;
    logic [15:0] vec_b;
    logic [19:0] mon;
    logic [15:0] last_sts;
    logic [15:0] last_cmd;
    logic [15:0] host_io_access;
    logic busy;
    logic ack;
    logic [15:0] rdata;
    logic arm;
    hsp_pkg::hsp_svc_t svc;
    logic seen;
    logic b_pend;
    logic iack_busy;
    logic iack_ack;
    logic [15:0] iack_vec;
  } hsp_state_t;

  hsp_state_t state_q;
  hsp_state_t state_d;

  logic take;
  logic done_evt;
  logic [15:0] set_bits;
  logic b_raise;
  logic dec_launch;
  logic dec_mode_ok;
  logic [2:0] dec_mode;
  logic dec_clear;
  logic dec_shut;
  logic dec_sts_wr;

  // ===================================================
  // helpers
  hsp_launch_decode u_decode (
    .svc_i(state_q.svc),
    .is_launch_o(dec_launch),
    .mode_ok_o(dec_mode_ok),
    .mode_o(dec_mode),
    .is_clear_o(dec_clear),
    .is_shut_o(dec_shut),
    .is_sts_wr_o(dec_sts_wr)
  );

  hsp_status_events u_events (
    .eng_i(eng_i),
    .done_i(done_evt),
    .b_pend_i(state_q.b_pend),
    .set_o(set_bits),
    .b_raise_o(b_raise)
  );

  // a new access is taken only once the previous cycle has ended
  assign take = host_i.req && !state_q.busy;
  assign done_evt = state_q.svc.req && fw_i.done;

  // ===================================================
  // next state
  always_comb begin
    state_d = state_q;
    state_d.ack = 1'b0;
    state_d.iack_ack = 1'b0;

    // host access
    if (take) begin
      state_d.busy = 1'b1;
      state_d.ack = 1'b1;
      if (hsp_pkg::is_sfr(host_i.addr)) begin
        // one outstanding function; extra ones are acked and dropped
        if (!state_q.svc.req && !state_q.arm) begin
          state_d.arm = 1'b1; // RL16
          state_d.svc.rd = !host_i.we;
          state_d.svc.addr = host_i.addr;
          if (host_i.we) begin
            state_d.host_io_access = host_i.wdata; // RL17
            state_d.svc.data = host_i.wdata;
          end
        end
        // reads return whatever the internal register holds
        state_d.rdata = state_q.host_io_access; // RL20
      end else if (host_i.we) begin
        state_d.rdata = 16'h0000;
        case (host_i.addr)
          hsp_pkg::OFF_VEC_A: state_d.vec_a = host_i.wdata; // RL15
          hsp_pkg::OFF_VEC_B: state_d.vec_b = host_i.wdata; // RL15
          hsp_pkg::OFF_CTRL: begin
            if (host_i.wdata[hsp_pkg::CTRL_CLR_BIT]) begin
              state_d.sts = hsp_pkg::STS_RESET; // RL6
              state_d.seen = 1'b0;
            end
          end
          // status word itself is read-only here
          default: state_d.rdata = 16'h0000; // RL5
        endcase
      end else begin
        case (host_i.addr)
          hsp_pkg::OFF_MON_LO: state_d.rdata = state_q.mon[15:0]; // RL1
          hsp_pkg::OFF_MON_HI: state_d.rdata = {12'h000, state_q.mon[19:16]}; // RL2
          hsp_pkg::OFF_LAST_STS: state_d.rdata = state_q.last_sts; // RL4
          hsp_pkg::OFF_LAST_CMD: state_d.rdata = state_q.last_cmd; // RL4
          hsp_pkg::OFF_VEC_A: state_d.rdata = state_q.vec_a;
          hsp_pkg::OFF_VEC_B: state_d.rdata = state_q.vec_b;
          hsp_pkg::OFF_RUN_STS: begin
            state_d.rdata = state_q.sts; // RL5
            // first read that sees done arms, the next one clears
            if (state_q.sts[hsp_pkg::ST_DONE]) begin
              if (state_q.seen) begin
                state_d.sts[hsp_pkg::ST_DONE] = 1'b0; // RL24
                state_d.seen = 1'b0;
              end else begin
                state_d.seen = 1'b1; // RL18
              end
            end
          end
          default: state_d.rdata = 16'h0000;
        endcase
      end
    end

    // bus cycle ends when the host drops its request
    if (state_q.busy && !host_i.req) begin
      state_d.busy = 1'b0;
      if (state_q.arm) begin
        state_d.arm = 1'b0;
        state_d.svc.req = 1'b1; // RL17
      end
    end

    // engine back in off state ends a shutdown; placed before completion
    // so that a shutdown or start finishing in the same cycle wins
    if (eng_i.to_off) begin
      state_d.sts[hsp_pkg::ST_MODE_HI:hsp_pkg::ST_MODE_LO] = hsp_pkg::MODE_OFF; // RL12
      state_d.sts[hsp_pkg::ST_SHUT] = 1'b0;
    end

    // firmware completion
    if (done_evt) begin
      state_d.svc.req = 1'b0;
      if (state_q.svc.rd) begin
        state_d.host_io_access = fw_i.data; // RL20
      end
      if (dec_clear || dec_sts_wr) begin
        state_d.sts = dec_sts_wr ? state_q.svc.data : hsp_pkg::STS_RESET; // RL6
        state_d.seen = 1'b0;
      end
      if (dec_shut) begin
        state_d.sts[hsp_pkg::ST_SHUT] = 1'b1; // RL11
      end
      if (dec_launch && dec_mode_ok) begin
        state_d.sts[hsp_pkg::ST_MODE_HI:hsp_pkg::ST_MODE_LO] = dec_mode; // RL12
        state_d.sts[hsp_pkg::ST_SHUT] = 1'b0;
      end
    end

    // interrupt acknowledge, one per request
    if (iack_req_i && !state_q.iack_busy) begin
      state_d.iack_busy = 1'b1;
      state_d.iack_ack = 1'b1;
      state_d.iack_vec = iack_lvl_b_i ? state_q.vec_b : state_q.vec_a; // RL15
      if (iack_lvl_b_i) begin
        state_d.b_pend = 1'b0;
      end
    end
    if (state_q.iack_busy && !iack_req_i) begin
      state_d.iack_busy = 1'b0;
    end

    // raise after acknowledge so a new request is not lost
    if (b_raise) begin
      state_d.b_pend = 1'b1; // RL13
    end

    // sticky events last, so a set beats any clear
    state_d.sts = state_d.sts | set_bits; // RL9

    // busy is a live view, not sticky; a clear counts from its bus cycle
    // until firmware is done, with no gap while it is only armed
    state_d.sts[hsp_pkg::ST_ACTIVE] = eng_i.running || eng_i.selftest_busy
      || ((state_d.svc.req || state_d.arm) && !state_d.svc.rd
      && state_d.svc.addr == hsp_pkg::OFF_CLEAR); // RL7

    // monitor ring tail only tracked in terminal/monitor mode
    if (eng_i.mon_we
        && state_q.sts[hsp_pkg::ST_MODE_HI:hsp_pkg::ST_MODE_LO] == hsp_pkg::MODE_TM) begin
      state_d.mon = eng_i.mon_addr; // RL1
    end
    if (eng_i.sts_we) begin
      state_d.last_sts = eng_i.sts_word; // RL4
    end
    if (eng_i.cmd_we) begin
      state_d.last_cmd = eng_i.cmd_word; // RL4
    end
  end

  // ===================================================
  // registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= '0; // RL6
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign host_ack_o = state_q.ack;
  assign host_rdata_o = state_q.rdata;
  assign iack_ack_o = state_q.iack_ack;
  assign iack_vec_o = state_q.iack_vec;
  assign svc_o = state_q.svc;
  assign run_status_o = state_q.sts;

  // ===================================================
  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i || !ce_i);

  logic no_evt;
  assign no_evt = set_bits == 16'h0000 && !done_evt;

  property p_mon_tail;
    eng_i.mon_we && state_q.sts[6:4] == 3'h4 && ce_i
      |=> state_q.mon == $past(eng_i.mon_addr);
  endproperty
  a_mon_tail: assert property (p_mon_tail) else $error("ring tail not captured"); // RL1

  property p_map_high;
    take && !host_i.we && host_i.addr == 8'h12 |=> host_ack_o && host_rdata_o[15:4] == 12'h000;
  endproperty
  a_map_high: assert property (p_map_high) else $error("map upper bits not zero"); // RL2

  property p_last_cmd;
    eng_i.cmd_we |=> state_q.last_cmd == $past(eng_i.cmd_word);
  endproperty
  a_last_cmd: assert property (p_last_cmd) else $error("command word not kept"); // RL4

  property p_ctrl_clear;
    take && host_i.we && host_i.addr == 8'h00 && host_i.wdata[5] && no_evt
      |=> run_status_o[14:0] == 15'h0000;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("control clear ignored"); // RL6

  property p_active;
    eng_i.running |=> run_status_o[15];
  endproperty
  a_active: assert property (p_active) else $error("active bit low while running"); // RL7

  property p_irq_a;
    eng_i.irq_a |=> run_status_o[14];
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("level-A request lost"); // RL8

  property p_after_cycle;
    $rose(svc_o.req) |-> !$past(host_i.req) && $past(state_q.arm);
  endproperty
  a_after_cycle: assert property (p_after_cycle) else $error("service before cycle end"); // RL17

  property p_done_held;
    done_evt ##1 (!take [*2]) |-> run_status_o[11] [*2];
  endproperty
  a_done_held: assert property (p_done_held) else $error("done bit not held"); // RL18

  property p_tm_mode;
    done_evt && dec_launch && state_q.svc.data == 16'h0003 && !eng_i.to_off
      |=> run_status_o[6:4] == 3'h4;
  endproperty
  a_tm_mode: assert property (p_tm_mode) else $error("terminal mode not shown"); // RL23

  property p_err_pwr;
    eng_i.err && eng_i.powerup |=> run_status_o[0];
  endproperty
  a_err_pwr: assert property (p_err_pwr) else $error("power-up error masked"); // RL14

  property p_clear_busy;
    state_q.arm && !state_q.svc.rd && state_q.svc.addr == 8'h88 |-> run_status_o[15];
  endproperty
  a_clear_busy: assert property (p_clear_busy) else $error("clear not active"); // RL7

  property p_iack_vec;
    iack_req_i && !state_q.iack_busy && iack_lvl_b_i
      |=> iack_vec_o == $past(state_q.vec_b);
  endproperty
  a_iack_vec: assert property (p_iack_vec) else $error("level-B vector wrong"); // RL15

endmodule : hsp_host_port
`default_nettype wire

/* File: logic/hsp_pkg.sv */
`default_nettype none
package hsp_pkg;

  // ===================================================
  // widths
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 8;
  localparam int unsigned MW = 20;

  // ===================================================
  // host port byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MON_LO = 8'h10;
  localparam logic [7:0] OFF_MON_HI = 8'h12;
  localparam logic [7:0] OFF_LAST_STS = 8'h14;
  localparam logic [7:0] OFF_LAST_CMD = 8'h16;
  localparam logic [7:0] OFF_RUN_STS = 8'h18;
  localparam logic [7:0] OFF_VEC_A = 8'h1a;
  localparam logic [7:0] OFF_VEC_B = 8'h1c;
  localparam logic [7:0] OFF_SFR_BASE = 8'h80;
  localparam logic [7:0] OFF_LAUNCH = 8'h80;
  localparam logic [7:0] OFF_CLEAR = 8'h88;
  localparam logic [7:0] OFF_SHUTDOWN = 8'h8a;
  localparam logic [7:0] OFF_STS_WR = 8'h98;

  // ===================================================
  // run status field positions
  localparam int ST_ACTIVE = 15;
  localparam int ST_IRQ_A = 14;
  localparam int ST_IRQ_B = 13;
  localparam int ST_B_DONE = 12;
  localparam int ST_DONE = 11;
  localparam int ST_F_ALU = 10;
  localparam int ST_F_HOST = 9;
  localparam int ST_F_LOOP = 8;
  localparam int ST_SHUT = 7;
  localparam int ST_MODE_HI = 6;
  localparam int ST_MODE_LO = 4;
  localparam int ST_B_LATE = 3;
  localparam int ST_ST_DONE = 2;
  localparam int ST_BIT_FAIL = 1;
  localparam int ST_ERR = 0;
  localparam int CTRL_CLR_BIT = 5;
  localparam logic [15:0] STS_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ===================================================
  // current mode codes and launch codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SIM = 3'h1;
  localparam logic [2:0] MODE_DIAG = 3'h2;
  localparam logic [2:0] MODE_TM = 3'h4;
  localparam logic [2:0] LAUNCH_SIM = 3'h1;
  localparam logic [2:0] LAUNCH_DIAG = 3'h2;
  localparam logic [2:0] LAUNCH_TM_INIT = 3'h3;
  localparam logic [2:0] LAUNCH_TM_QUICK = 3'h4;

  // ===================================================
  // carriers
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } hsp_host_req_t;

  typedef struct packed {
    logic running;
    logic selftest_busy;
    logic powerup;
    logic irq_a;
    logic irq_b;
    logic b_on_done;
    logic alu_fail;
    logic host_fail;
    logic loop_fail;
    logic st_done;
    logic bit_fail;
    logic err;
    logic err_mask;
    logic to_off;
    logic mon_we;
    logic [19:0] mon_addr;
    logic sts_we;
    logic [15:0] sts_word;
    logic cmd_we;
    logic [15:0] cmd_word;
  } hsp_engine_t;

  typedef struct packed {
    logic done;
    logic [15:0] data;
  } hsp_fw_t;

  typedef struct packed {
    logic req;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } hsp_svc_t;

  // special-function window decode
  function automatic logic is_sfr(input logic [7:0] a);
    return a[7];
  endfunction : is_sfr

endpackage : hsp_pkg
`default_nettype wire

/* File: logic/hsp_launch_decode.sv */
`default_nettype none
// ===================================================
// decodes the pending special function
module hsp_launch_decode (
  // pending request
  input wire hsp_pkg::hsp_svc_t svc_i,
  // decoded actions
  output logic is_launch_o,
  output logic mode_ok_o,
  output logic [2:0] mode_o,
  output logic is_clear_o,
  output logic is_shut_o,
  output logic is_sts_wr_o
);

  // only writes carry an action; reads just fetch data
  assign is_launch_o = !svc_i.rd && svc_i.addr == hsp_pkg::OFF_LAUNCH;
  assign is_clear_o = !svc_i.rd && svc_i.addr == hsp_pkg::OFF_CLEAR;
  assign is_shut_o = !svc_i.rd && svc_i.addr == hsp_pkg::OFF_SHUTDOWN;
  assign is_sts_wr_o = !svc_i.rd && svc_i.addr == hsp_pkg::OFF_STS_WR;

  // both terminal/monitor starts report the same mode
  always_comb begin
    mode_ok_o = 1'b1;
    case (svc_i.data[2:0])
      hsp_pkg::LAUNCH_SIM: mode_o = hsp_pkg::MODE_SIM;
      hsp_pkg::LAUNCH_DIAG: mode_o = hsp_pkg::MODE_DIAG;
      hsp_pkg::LAUNCH_TM_INIT: mode_o = hsp_pkg::MODE_TM; // RL23
      hsp_pkg::LAUNCH_TM_QUICK: mode_o = hsp_pkg::MODE_TM; // RL23
      default: begin
        mode_o = hsp_pkg::MODE_OFF;
        mode_ok_o = 1'b0;
      end
    endcase
    // upper data bits must be zero or the start is ignored
    if (svc_i.data[15:3] != 13'h0000) begin
      mode_ok_o = 1'b0; // RL22
    end
  end

endmodule : hsp_launch_decode
`default_nettype wire

/* File: logic/hsp_status_events.sv */
`default_nettype none
// ===================================================
// turns engine events into status set bits
module hsp_status_events (
  // inputs
  input wire hsp_pkg::hsp_engine_t eng_i,
  input wire logic done_i,
  input wire logic b_pend_i,
  // outputs
  output logic [15:0] set_o,
  output logic b_raise_o
);

  logic b_done;

  assign b_done = done_i && eng_i.b_on_done;
  assign b_raise_o = eng_i.irq_b || b_done;

  // each set bit is sticky in the caller, set wins over clears
  always_comb begin
    set_o = 16'h0000;
    set_o[hsp_pkg::ST_IRQ_A] = eng_i.irq_a; // RL8
    set_o[hsp_pkg::ST_IRQ_B] = eng_i.irq_b; // RL8
    set_o[hsp_pkg::ST_B_DONE] = b_done; // RL9
    set_o[hsp_pkg::ST_DONE] = done_i; // RL9
    set_o[hsp_pkg::ST_F_ALU] = eng_i.alu_fail; // RL10
    set_o[hsp_pkg::ST_F_HOST] = eng_i.host_fail; // RL10
    set_o[hsp_pkg::ST_F_LOOP] = eng_i.loop_fail; // RL10
    set_o[hsp_pkg::ST_B_LATE] = b_raise_o && b_pend_i; // RL13
    set_o[hsp_pkg::ST_ST_DONE] = eng_i.st_done; // RL13
    set_o[hsp_pkg::ST_BIT_FAIL] = eng_i.bit_fail; // RL13
    // mask ignored while powering up
    set_o[hsp_pkg::ST_ERR] = eng_i.err && (!eng_i.err_mask || eng_i.powerup); // RL14
  end

endmodule : hsp_status_events
`default_nettype wire

/* File: verification/hsp_fw_model.sv */
`default_nettype none
// ==========
// firmware stand-in: services the pending function after a set latency
module hsp_fw_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // pending function and service latency in cycles
  input wire hsp_pkg::hsp_svc_t svc_i,
  input wire logic [7:0] lat_i,
  // completion towards the port
  output hsp_pkg::hsp_fw_t fw_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q;
  logic busy_q;

  // data means nothing outside the done pulse, so it toggles to expose misuse
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      fw_o <= '0;
    end else begin
      fw_o.done <= 1'b0;
      fw_o.data <= ~fw_o.data;
      if (svc_i.req && !busy_q && !fw_o.done) begin
        busy_q <= 1'b1;
        cnt_q <= lat_i;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        fw_o.done <= 1'b1;
        fw_o.data <= svc_i.rd ? {8'hc3, svc_i.addr} : 16'h0000;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : hsp_fw_model
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // stimulus and observation
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  hsp_pkg::hsp_host_req_t hreq = '0;
  logic iack_req = 1'b0;
  logic iack_b = 1'b0;
  hsp_pkg::hsp_engine_t eng = '0;
  logic [7:0] lat = 8'h00;
  logic host_ack, iack_ack;
  logic [15:0] host_rdata, iack_vec, run_status, rd, st, exp;
  hsp_pkg::hsp_svc_t svc;
  hsp_pkg::hsp_fw_t fw;
  int n_fail = 0;
  int compares = 0;
  logic [7:0] offs[8] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h20};
  logic [2:0] codes[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [2:0] modes[4] = '{3'h1, 3'h2, 3'h4, 3'h4};
  int bitpos[7] = '{14, 10, 9, 8, 2, 1, 13};

  // 250 MHz board clock
  always #2 mclk_i = ~mclk_i;

  hsp_host_port u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
    .host_i(hreq), .host_ack_o(host_ack), .host_rdata_o(host_rdata),
    .iack_req_i(iack_req), .iack_lvl_b_i(iack_b), .iack_ack_o(iack_ack),
    .iack_vec_o(iack_vec), .eng_i(eng), .fw_i(fw), .svc_o(svc),
    .run_status_o(run_status)
  );

  hsp_fw_model u_fw (
    .mclk_i(mclk_i), .reset_i(reset_i), .svc_i(svc), .lat_i(lat), .fw_o(fw)
  );

  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // ack and data looked at on falling edges where they are settled
  task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] wd,
                     output logic [15:0] r);
    int n;
    n = 0;
    @(negedge mclk_i);
    hreq = '{req: 1'b1, we: we, addr: a, wdata: wd};
    do begin
      @(negedge mclk_i);
      n++;
    end while (host_ack !== 1'b1 && n < 20);
    r = host_rdata;
    chk("host ack", 16'h0001, {15'h0000, host_ack});
    @(negedge mclk_i);
    hreq.req = 1'b0;
  endtask : acc

  task automatic iack(input logic lvl, output logic [15:0] v);
    int n;
    n = 0;
    @(negedge mclk_i);
    iack_req = 1'b1;
    iack_b = lvl;
    do begin
      @(negedge mclk_i);
      n++;
    end while (iack_ack !== 1'b1 && n < 20);
    v = iack_vec;
    chk("iack ack", 16'h0001, {15'h0000, iack_ack});
    @(negedge mclk_i);
    iack_req = 1'b0;
  endtask : iack

  // polls for completion, then the extra read that clears it
  task automatic hs(output logic [15:0] s);
    logic [15:0] d;
    int n;
    n = 0;
    s = '0;
    while (s[11] !== 1'b1 && n < 40) begin
      acc(1'b0, hsp_pkg::OFF_RUN_STS, 16'h0000, s);
      n++;
    end
    chk("done bit seen", 16'h0001, {15'h0000, s[11]});
    acc(1'b0, hsp_pkg::OFF_RUN_STS, 16'h0000, d);
    acc(1'b0, hsp_pkg::OFF_RUN_STS, 16'h0000, d);
    chk("done bit after clearing read", 16'h0000, {15'h0000, d[11]});
  endtask : hs

  // one-cycle engine pulse; levels in eng are kept
  task automatic evt(input int k);
    hsp_pkg::hsp_engine_t b;
    b = eng;
    @(negedge mclk_i);
    case (k)
      0: eng.irq_a = 1'b1;
      1: eng.alu_fail = 1'b1;
      2: eng.host_fail = 1'b1;
      3: eng.loop_fail = 1'b1;
      4: eng.st_done = 1'b1;
      5: eng.bit_fail = 1'b1;
      6: eng.irq_b = 1'b1;
      7: eng.err = 1'b1;
      8: begin
        eng.mon_we = 1'b1;
        eng.sts_we = 1'b1;
        eng.cmd_we = 1'b1;
      end
      default: eng.to_off = 1'b1;
    endcase
    @(negedge mclk_i);
    eng = b;
  endtask : evt

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // ==========
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  // test sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 1'b0;
    foreach (offs[i]) begin
      acc(1'b0, offs[i], 16'h0000, rd);
      chk("reset value", 16'h0000, rd);
    end
    acc(1'b1, hsp_pkg::OFF_LAST_STS, 16'h1234, rd);
    acc(1'b0, hsp_pkg::OFF_LAST_STS, 16'h0000, rd);
    chk("read-only word", 16'h0000, rd);
    $display("test reset_values finished");
    acc(1'b1, hsp_pkg::OFF_VEC_A, 16'h5a01, rd);
    acc(1'b1, hsp_pkg::OFF_VEC_B, 16'h5a02, rd);
    acc(1'b0, hsp_pkg::OFF_VEC_A, 16'h0000, rd);
    chk("vector a", 16'h5a01, rd);
    acc(1'b0, hsp_pkg::OFF_VEC_B, 16'h0000, rd);
    chk("vector b", 16'h5a02, rd);
    iack(1'b0, rd);
    chk("ack vector a", 16'h5a01, rd);
    iack(1'b1, rd);
    chk("ack vector b", 16'h5a02, rd);
    $display("test vectors finished");
    // every start code, firmware alternating prompt and slow
    for (int i = 0; i < 4; i++) begin
      lat = (i % 2 == 1) ? 8'h0c : 8'h00;
      acc(1'b1, hsp_pkg::OFF_LAUNCH, {13'h0000, codes[i]}, rd);
      chk("function before cycle end", 16'h0000, {15'h0000, svc.req});
      chk("latched command data", {13'h0000, codes[i]}, svc.data);
      hs(st);
      chk("mode", {13'h0000, modes[i]}, {13'h0000, st[6:4]});
      chk("done bit", 16'h0001, {15'h0000, st[11]});
    end
    // a start with a reserved bit set completes but leaves the mode alone
    acc(1'b1, hsp_pkg::OFF_LAUNCH, 16'h0009, rd);
    hs(st);
    chk("reserved start bits", 16'h0004, {13'h0000, st[6:4]});
    $display("test start_modes finished");
    eng.mon_addr = 20'habcde;
    eng.sts_word = 16'h4321;
    eng.cmd_word = 16'h8765;
    evt(8);
    acc(1'b0, hsp_pkg::OFF_MON_LO, 16'h0000, rd);
    chk("ring tail low", 16'hbcde, rd);
    acc(1'b0, hsp_pkg::OFF_MON_HI, 16'h0000, rd);
    chk("ring tail high", 16'h000a, rd);
    acc(1'b0, hsp_pkg::OFF_LAST_STS, 16'h0000, rd);
    chk("last status word", 16'h4321, rd);
    acc(1'b0, hsp_pkg::OFF_LAST_CMD, 16'h0000, rd);
    chk("last command word", 16'h8765, rd);
    $display("test captured_words finished");
    exp = 16'h0040;
    for (int k = 0; k < 7; k++) begin
      evt(k);
      exp[bitpos[k]] = 1'b1;
      chk("run status", exp, run_status);
    end
    evt(6);
    exp[3] = 1'b1;
    chk("late level b", exp, run_status);
    eng.running = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("active bit", exp | 16'h8000, run_status);
    eng.running = 1'b0;
    eng.err_mask = 1'b1;
    repeat (2) @(negedge mclk_i);
    evt(7);
    chk("masked error", exp, run_status);
    eng.powerup = 1'b1;
    evt(7);
    exp[0] = 1'b1;
    chk("power-up error", exp, run_status);
    eng.powerup = 1'b0;
    $display("test status_events finished");
    acc(1'b1, hsp_pkg::OFF_CTRL, 16'h0020, rd);
    @(negedge mclk_i);
    chk("control clear", 16'h0000, run_status);
    acc(1'b1, hsp_pkg::OFF_RUN_STS, 16'hffff, rd);
    acc(1'b0, hsp_pkg::OFF_RUN_STS, 16'h0000, rd);
    chk("direct status write", 16'h0000, rd);
    acc(1'b1, hsp_pkg::OFF_SHUTDOWN, 16'h0000, rd);
    hs(st);
    chk("shutdown bit", 16'h0001, {15'h0000, st[7]});
    evt(9);
    chk("back to off", 16'h0000, run_status);
    acc(1'b1, hsp_pkg::OFF_STS_WR, 16'h0105, rd);
    hs(st);
    chk("status write", 16'h0905, st);
    $display("test status_writes finished");
    lat = 8'h14;
    acc(1'b1, hsp_pkg::OFF_CLEAR, 16'h0000, rd);
    acc(1'b0, hsp_pkg::OFF_RUN_STS, 16'h0000, rd);
    chk("active during clear", 16'h0001, {15'h0000, rd[15]});
    hs(st);
    chk("status after clear", 16'h0800, st);
    $display("test clear_command finished");
    // deferred window read: first answer is stale, the repeat carries the value
    lat = 8'h03;
    eng.b_on_done = 1'b1;
    acc(1'b0, 8'h9c, 16'h0000, rd);
    hs(st);
    chk("level b on completion", 16'h0001, {15'h0000, st[12]});
    acc(1'b0, 8'h9c, 16'h0000, rd);
    chk("window read", 16'hc39c, rd);
    hs(st);
    $display("test window_read finished");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
